// [shared/timer_regs_pkg.sv]
`default_nettype none
package timer_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets on the byte-wide peripheral register port.
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_BV_CLEAR  = 8'h06; // Buffer-valid clear alias.
    localparam logic [7:0] OFS_BV_SET    = 8'h07; // Buffer-valid set alias.
    localparam logic [7:0] OFS_EVENT     = 8'h09; // Event control.
    localparam logic [7:0] OFS_INT_EN    = 8'h0a; // Interrupt enables.
    localparam logic [7:0] OFS_INT_FLAGS = 8'h0b; // Interrupt flags.
    localparam logic [7:0] OFS_DEBUG     = 8'h0e; // Debug control.
    localparam logic [7:0] OFS_STAGING   = 8'h0f; // Shared staging byte.
    localparam logic [7:0] OFS_COUNTER   = 8'h20; // Counter low byte.
    localparam logic [7:0] OFS_PERIOD    = 8'h26; // Period low byte.
    localparam logic [7:0] OFS_PER_BUF   = 8'h36; // Period buffer low byte.
    localparam logic [7:0] OFS_CMP_BUF   = 8'h38; // Compare 0 buffer low byte.
    localparam logic [7:0] OFS_HIGH_STEP = 8'h01; // High byte sits one above.
    localparam logic [7:0] OFS_CMP_STEP  = 8'h02; // Stride between channels.

    // ------------------------------------------------------------
    // Field positions and widths.
    // ------------------------------------------------------------
    localparam int NUM_CHANNELS = 3;  // Compare channels.
    localparam int BV_PERIOD    = 0;  // Period buffer-valid bit.
    localparam int BV_CMP0      = 1;  // First compare buffer-valid bit.
    localparam int BV_WIDTH     = 4;  // Buffer-valid bits in use.
    localparam int INT_WRAP     = 0;  // Wrap flag and enable bit.
    localparam int INT_CMP0     = 4;  // First compare flag and enable bit.
    localparam int EV_ENABLE    = 0;  // Count-on-event enable bit.
    localparam int EV_ACT_LO    = 1;  // Event action field, low bit.
    localparam int EV_ACT_HI    = 3;  // Event action field, high bit.
    localparam int DBG_RUN      = 0;  // Run-while-halted bit.

    // ------------------------------------------------------------
    // Reset values and masks.
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00; // Byte registers.
    localparam logic [15:0] RST_COUNTER    = 16'h0000;
    localparam logic [15:0] RST_PERIOD     = 16'hffff;
    localparam logic [7:0]  MASK_BV        = 8'h0f; // Implemented valid bits.
    localparam logic [7:0]  MASK_EVENT     = 8'h0f; // Implemented event bits.
    localparam logic [7:0]  MASK_INT       = 8'h71; // Implemented flag bits.
    localparam logic [7:0]  MASK_DEBUG     = 8'h01; // Implemented debug bits.

    // ------------------------------------------------------------
    // Event action codes and waveform mode codes.
    // ------------------------------------------------------------
    localparam logic [2:0] ACT_RISING_EDGE  = 3'h0;
    localparam logic [2:0] ACT_BOTH_EDGES   = 3'h1;
    localparam logic [2:0] ACT_LEVEL_HIGH   = 3'h2;
    localparam logic [2:0] ACT_DIRECTION    = 3'h3;
    localparam logic [2:0] MODE_NORMAL      = 3'h0;
    localparam logic [2:0] MODE_FREQUENCY   = 3'h1;
    localparam logic [2:0] MODE_SINGLE      = 3'h3;
    localparam logic [2:0] MODE_DUAL_TOP    = 3'h5;
    localparam logic [2:0] MODE_DUAL_BOTH   = 3'h6;
    localparam logic [2:0] MODE_DUAL_BOTTOM = 3'h7;

    // One register port access: strobes with address and write data.
    typedef struct packed {
        logic       wr;    // Write strobe, one cycle.
        logic       rd;    // Read strobe, one cycle.
        logic [7:0] addr;  // Byte offset.
        logic [7:0] wdata; // Write data.
    } bus_req_t;

    // The three compare values held outside this block.
    typedef logic [NUM_CHANNELS-1:0][15:0] compare_set_t;

endpackage : timer_regs_pkg
`default_nettype wire

// [hw/timer_buffer_event_irq_regs.sv]
`timescale 1ns/100ps
`default_nettype none

module timer_buffer_event_irq_regs (
    // Clock and reset.
    input  wire logic                         clk,
    input  wire logic                         nrst,
    // Register port.
    input  wire timer_regs_pkg::bus_req_t     busReq,
    output var  logic [7:0]                   readData,
    // Timer context supplied by the surrounding timer.
    input  wire logic                         timerEnable,
    input  wire logic                         prescaleTick,
    input  wire logic                         eventIn,
    input  wire logic                         haltedByDebugger,
    input  wire logic [2:0]                   waveformMode,
    input  wire logic                         lockUpdate,
    input  wire logic                         updateCommand,
    input  wire logic [15:0]                  periodBuffer,
    input  wire timer_regs_pkg::compare_set_t compareValues,
    // Results.
    output var  logic [15:0]                  counterValue,
    output var  logic [15:0]                  periodValue,
    output var  logic [3:0]                   bufferValid,
    output var  logic [2:0]                   compareIrq,
    output var  logic                         wrapIrq
);
    import timer_regs_pkg::*;

    // ------------------------------------------------------------
    // Address decoding.
    // ------------------------------------------------------------

    // True when the access hits the high byte of a 16-bit register.
    function automatic logic hitHigh(input logic [7:0] addr, input logic [7:0] base);
        hitHigh = (addr == base + OFS_HIGH_STEP);
    endfunction : hitHigh

    // Low byte address of compare buffer n.
    function automatic logic [7:0] cmpBufBase(input int n);
        cmpBufBase = OFS_CMP_BUF + 8'(n) * OFS_CMP_STEP;
    endfunction : cmpBufBase

    logic [7:0]  bv_q, bv_d;             // Buffer-valid bits.
    logic [7:0]  event_q;                // Event control.
    logic [7:0]  intEn_q;                // Interrupt enables.
    logic [7:0]  flags_q, flags_d;       // Interrupt flags.
    logic [7:0]  debug_q;                // Debug control.
    logic [7:0]  staging_q;              // Shared staging byte.
    logic [15:0] cnt_q, cnt_d;           // Counter.
    logic [15:0] per_q;                  // Period.
    logic        eventPrev_q;            // Event level one cycle back.
    logic [7:0]  rdata_q;                // Registered read data.
    logic [2:0]  cmpIrq_q;               // Registered compare requests.
    logic        wrapIrq_q;              // Registered wrap request.

    wire wr = busReq.wr;                  // Write strobe.
    wire rd = busReq.rd;                  // Read strobe.
    wire [7:0] ad = busReq.addr;          // Access address.
    wire [7:0] wd = busReq.wdata;         // Write data.

    // Low-byte writes to any 16-bit register load the staging byte.
    wire lowCnt = (ad == OFS_COUNTER);
    wire lowPer = (ad == OFS_PERIOD);
    wire lowBuf = (ad == OFS_PER_BUF) || (ad == cmpBufBase(0))
               || (ad == cmpBufBase(1)) || (ad == cmpBufBase(2));
    wire wrCntHigh = wr && hitHigh(ad, OFS_COUNTER);   // Completes counter write.
    wire wrPerHigh = wr && hitHigh(ad, OFS_PERIOD);    // Completes period write.

    // A buffer counts as written when its high byte lands.
    logic [3:0] bufWritten;
    always_comb begin
        bufWritten = 4'h0;
        bufWritten[BV_PERIOD] = wr && hitHigh(ad, OFS_PER_BUF);
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            bufWritten[BV_CMP0 + n] = wr && hitHigh(ad, cmpBufBase(n));
        end
    end

    // ------------------------------------------------------------
    // Counting control.
    // ------------------------------------------------------------
    wire [2:0] action  = event_q[EV_ACT_HI:EV_ACT_LO];
    wire       evCount = event_q[EV_ENABLE];
    // A debugger halt freezes the timer unless the run bit is set.
    wire running = timerEnable && (!haltedByDebugger || debug_q[DBG_RUN]);
    wire rise = eventIn && !eventPrev_q;
    wire fall = !eventIn && eventPrev_q;

    // Pick the source of a count step from the event action.
    logic evStep;
    always_comb begin
        case (action)
            ACT_RISING_EDGE: evStep = rise;
            ACT_BOTH_EDGES:  evStep = rise || fall;
            ACT_LEVEL_HIGH:  evStep = prescaleTick && eventIn;
            ACT_DIRECTION:   evStep = prescaleTick;
            default:         evStep = 1'b0;
        endcase
    end
    // Without event counting the plain prescaled tick drives the counter.
    wire step = running && (evCount ? evStep : prescaleTick);
    // The event level is looked at only on the step itself.
    wire down = evCount && (action == ACT_DIRECTION) && eventIn;

    // Top is the period except in frequency mode, where channel 0 sets it.
    wire [15:0] top = (waveformMode == MODE_FREQUENCY) ? compareValues[0] : per_q;
    wire wrapUp   = step && !down && (cnt_q == top);
    wire wrapDown = step && down && (cnt_q == RST_COUNTER);

    // Modes that flag the wrap at top, at bottom, or at both.
    wire modeTop = (waveformMode == MODE_NORMAL) || (waveformMode == MODE_FREQUENCY)
                || (waveformMode == MODE_DUAL_TOP) || (waveformMode == MODE_DUAL_BOTH);
    wire modeBottom = (waveformMode == MODE_SINGLE) || (waveformMode == MODE_DUAL_BOTH)
                   || (waveformMode == MODE_DUAL_BOTTOM);
    wire wrapEvent = (wrapUp && modeTop) || (wrapDown && modeBottom);

    // Normal and frequency modes update at top; every other mode updates at bottom,
    // so the dual-slope top-flag mode must not pick the top wrap here.
    wire upModes  = (waveformMode == MODE_NORMAL) || (waveformMode == MODE_FREQUENCY);
    wire updateHw = upModes ? wrapUp : wrapDown;
    // Lock holds off the automatic update; the command always transfers.
    wire transfer = (updateHw && !lockUpdate) || updateCommand;

    // Software write of the counter wins over a count step in that cycle.
    always_comb begin
        if (wrCntHigh) begin
            cnt_d = {wd, staging_q};
        end else if (wrapUp) begin
            cnt_d = RST_COUNTER;
        end else if (wrapDown) begin
            cnt_d = top;
        end else if (step) begin
            cnt_d = down ? cnt_q - 16'h0001 : cnt_q + 16'h0001;
        end else begin
            cnt_d = cnt_q;
        end
    end

    // ------------------------------------------------------------
    // Buffer-valid and flag next values.
    // ------------------------------------------------------------

    // Hardware and the set alias win over clearing in the same cycle.
    logic [7:0] bvSet, bvClr;
    always_comb begin
        bvSet = {4'h0, bufWritten};
        if (wr && ad == OFS_BV_SET) begin
            bvSet = bvSet | (wd & MASK_BV);
        end
        bvClr = transfer ? MASK_BV : 8'h00;
        if (wr && ad == OFS_BV_CLEAR) begin
            bvClr = bvClr | (wd & MASK_BV);
        end
        bv_d = (bv_q & ~bvClr) | bvSet;
    end

    // Compare matches and the wrap event set flags; a one clears them.
    logic [7:0] flagSet;
    always_comb begin
        flagSet = 8'h00;
        flagSet[INT_WRAP] = wrapEvent;
        for (int n = 0; n < NUM_CHANNELS; n++) begin
            flagSet[INT_CMP0 + n] = (cnt_q == compareValues[n]);
        end
        flags_d = flags_q;
        if (wr && ad == OFS_INT_FLAGS) begin
            flags_d = flags_q & ~(wd & MASK_INT);
        end
        flags_d = flags_d | flagSet;
    end

    // ------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------
    logic [7:0] readMux;
    always_comb begin
        case (ad)
            OFS_BV_CLEAR, OFS_BV_SET: readMux = bv_q;
            OFS_EVENT:                readMux = event_q;
            OFS_INT_EN:               readMux = intEn_q;
            OFS_INT_FLAGS:            readMux = flags_q;
            OFS_DEBUG:                readMux = debug_q;
            OFS_STAGING:              readMux = staging_q;
            OFS_COUNTER:              readMux = cnt_q[7:0];
            OFS_PERIOD:               readMux = per_q[7:0];
            default: begin
                // Counter and period high bytes come from the staging byte; all else reads zero.
                readMux = (hitHigh(ad, OFS_COUNTER) || hitHigh(ad, OFS_PERIOD))
                        ? staging_q : RST_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------

    // Plain read/write control bytes.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            event_q <= RST_BYTE;
            intEn_q <= RST_BYTE;
            debug_q <= RST_BYTE;
        end else if (wr) begin
            if (ad == OFS_EVENT) event_q <= wd & MASK_EVENT;
            if (ad == OFS_INT_EN) intEn_q <= wd & MASK_INT;
            if (ad == OFS_DEBUG) debug_q <= wd & MASK_DEBUG;
        end
    end

    // Staging byte: low-byte writes fill it, counter and period low-byte reads park the high byte.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            staging_q <= RST_BYTE;
        end else if (wr && (ad == OFS_STAGING || lowCnt || lowPer || lowBuf)) begin
            staging_q <= wd;
        end else if (rd && lowCnt) begin
            staging_q <= cnt_q[15:8];
        end else if (rd && lowPer) begin
            staging_q <= per_q[15:8];
        end
    end

    // Period: software write, or buffer transfer when the buffer is valid.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            per_q <= RST_PERIOD;
        end else if (wrPerHigh) begin
            per_q <= {wd, staging_q};
        end else if (transfer && bv_q[BV_PERIOD]) begin
            per_q <= periodBuffer;
        end
    end

    // Counter, valid bits, flags and event history.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cnt_q       <= RST_COUNTER;
            bv_q        <= RST_BYTE;
            flags_q     <= RST_BYTE;
            eventPrev_q <= 1'b0;
        end else begin
            cnt_q       <= cnt_d;
            bv_q        <= bv_d;
            flags_q     <= flags_d;
            eventPrev_q <= eventIn;
        end
    end

    // Registered outputs: read data and interrupt requests.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata_q   <= RST_BYTE;
            cmpIrq_q  <= 3'h0;
            wrapIrq_q <= 1'b0;
        end else begin
            rdata_q   <= rd ? readMux : RST_BYTE;
            cmpIrq_q  <= flags_q[INT_CMP0 +: NUM_CHANNELS]
                       & intEn_q[INT_CMP0 +: NUM_CHANNELS];
            wrapIrq_q <= flags_q[INT_WRAP] && intEn_q[INT_WRAP];
        end
    end

    assign readData     = rdata_q;
    assign counterValue = cnt_q;
    assign periodValue  = per_q;
    assign bufferValid  = bv_q[3:0];
    assign compareIrq   = cmpIrq_q;
    assign wrapIrq      = wrapIrq_q;

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------
    cmp_bv_set_a: assert property (@(posedge clk) disable iff (!nrst)
        wr && hitHigh(ad, OFS_CMP_BUF) |=> bv_q[BV_CMP0])
        else $error("Compare 0 buffer write did not set its valid bit.");

    per_bv_set_a: assert property (@(posedge clk) disable iff (!nrst)
        wr && hitHigh(ad, OFS_PER_BUF) |=> bv_q[BV_PERIOD])
        else $error("Period buffer write did not set its valid bit.");

    bv_update_clear_a: assert property (@(posedge clk) disable iff (!nrst)
        transfer && !wr |=> bv_q == RST_BYTE)
        else $error("Update left a buffer-valid bit set.");

    bv_set_alias_a: assert property (@(posedge clk) disable iff (!nrst)
        wr && ad == OFS_BV_SET && !transfer |=> bv_q == ($past(bv_q) | ($past(wd) & MASK_BV)))
        else $error("Set alias changed bits other than those written as one.");

    rise_count_a: assert property (@(posedge clk) disable iff (!nrst)
        !eventIn ##1 (running && evCount && action == ACT_RISING_EDGE && eventIn && !wr)
        |=> cnt_q != $past(cnt_q))
        else $error("Rising event edge did not move the counter.");

    level_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        evCount && action == ACT_LEVEL_HIGH && !eventIn && !wr |=> $stable(cnt_q))
        else $error("Counter moved while the event input was low.");

    debug_freeze_a: assert property (@(posedge clk) disable iff (!nrst)
        haltedByDebugger && !debug_q[DBG_RUN] && !wr |=> $stable(cnt_q))
        else $error("Counter moved during a debugger halt.");

    flag_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
        flags_q[INT_WRAP] && !(wr && ad == OFS_INT_FLAGS) |=> flags_q[INT_WRAP])
        else $error("Wrap flag cleared without a write of one.");

    compare_match_a: assert property (@(posedge clk) disable iff (!nrst)
        cnt_q == compareValues[1] |=> flags_q[INT_CMP0 + 1])
        else $error("Compare 1 match did not set its flag.");

    irq_follow_a: assert property (@(posedge clk) disable iff (!nrst)
        ##1 wrapIrq == ($past(flags_q[INT_WRAP]) && $past(intEn_q[INT_WRAP])))
        else $error("Wrap request does not follow flag and enable.");

endmodule : timer_buffer_event_irq_regs
`default_nettype wire

// [dv/tb_timer_buffer_event_irq_regs.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_timer_buffer_event_irq_regs;
    import timer_regs_pkg::*;
    // ------------------------------------------------------------
    // Stimulus, observed outputs and the bench's own model state.
    // ------------------------------------------------------------
    logic         clk, nrst, timerEnable, prescaleTick, eventIn, haltedByDebugger;
    logic         lockUpdate, updateCommand, wrapIrq, prevEv, src, run_while_halted;
    logic [2:0]   waveformMode, compareIrq;
    logic [3:0]   bufferValid;
    logic [7:0]   readData, b, r;
    logic [15:0]  periodBuffer, counterValue, periodValue, model, rv;
    bus_req_t     busReq;
    compare_set_t compareValues;
    int           n_mismatch, compares;
    logic [7:0]   zeroRegs [7] = '{8'h07, 8'h09, 8'h0a, 8'h0b, 8'h0e, 8'h0f, 8'h10};

    timer_buffer_event_irq_regs DUT (.clk(clk), .nrst(nrst), .busReq(busReq),
        .readData(readData), .timerEnable(timerEnable), .prescaleTick(prescaleTick),
        .eventIn(eventIn), .haltedByDebugger(haltedByDebugger), .waveformMode(waveformMode),
        .lockUpdate(lockUpdate), .updateCommand(updateCommand), .periodBuffer(periodBuffer),
        .compareValues(compareValues), .counterValue(counterValue),
        .periodValue(periodValue), .bufferValid(bufferValid), .compareIrq(compareIrq),
        .wrapIrq(wrapIrq));

    // ------------------------------------------------------------
    // Shared tasks: comparison, byte and word register accesses.
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // A write is taken at the rising edge between two falling edges.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        busReq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge clk);
        busReq = '0;
    endtask : wr
    // Read data stands for one cycle after the taking edge.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        busReq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge clk);
        busReq = '0;
        d = readData;
    endtask : rd
    // Words always go low byte first so the staging byte pairs them.
    task automatic wr16(input logic [7:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a + OFS_HIGH_STEP, v[15:8]);
    endtask : wr16
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[7:0]);
        rd(a + OFS_HIGH_STEP, v[15:8]);
    endtask : rd16
    // One count step: up wraps at top, down from zero reloads top.
    function automatic logic [15:0] nextCount(input logic [15:0] c, input logic dn);
        return dn ? ((c == 16'h0000) ? 16'hffff : c - 16'h0001)
                  : ((c == 16'hffff) ? 16'h0000 : c + 16'h0001);
    endfunction : nextCount
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog far beyond the few hundred cycles the tests need.
    initial begin
        #(20000 * 10);
        n_mismatch++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        {nrst, timerEnable, prescaleTick, eventIn, haltedByDebugger} = '0;
        {lockUpdate, updateCommand, waveformMode, periodBuffer} = '0;
        busReq = '0;
        compareValues = '{default: 16'h8000};
        void'($urandom(2));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        // Reset values, unmapped offset and the staging byte.
        foreach (zeroRegs[k]) begin
            rd(zeroRegs[k], b);
            check(16'(b), 16'h0000);
        end
        rd16(OFS_COUNTER, rv);
        check(rv, RST_COUNTER);
        rd16(OFS_PERIOD, rv);
        check(rv, 16'hffff);
        r = 8'($urandom);
        wr(OFS_STAGING, r);
        rd(OFS_STAGING, b);
        check(16'(b), 16'(r));
        // Every event action, then plain tick counting, under random halts.
        for (int cfg = 0; cfg < 5; cfg++) begin
            run_while_halted = 1'($urandom);
            wr(OFS_DEBUG, {7'h00, run_while_halted});
            wr(OFS_EVENT, (cfg < 4) ? {4'h0, 3'(cfg), 1'b1} : 8'h00);
            model = 16'($urandom);
            wr16(OFS_COUNTER, model);
            rd16(OFS_COUNTER, rv);
            check(rv, model);
            timerEnable = 1'b1;
            for (int i = 0; i <= 40; i++) begin
                prevEv = eventIn;
                eventIn = (i < 40) ? 1'($urandom) : 1'b0;
                prescaleTick = (i < 40) ? 1'($urandom) : 1'b0;
                haltedByDebugger = (i < 40) ? ($urandom % 4 == 0) : 1'b0;
                src = (cfg == 0) ? (eventIn & ~prevEv) : (cfg == 1) ? (eventIn ^ prevEv)
                    : (cfg == 2) ? (prescaleTick & eventIn) : prescaleTick;
                if ((!haltedByDebugger || run_while_halted) && src) begin
                    model = nextCount(model, (cfg == 3) && eventIn);
                end
                @(negedge clk);
            end
            check(counterValue, model);
            timerEnable = 1'b0;
        end
        // Buffer high-byte writes set their valid bits one by one.
        for (int n = 0; n < 4; n++) begin
            wr16(OFS_PER_BUF + 8'(2 * n), 16'($urandom));
            check(16'(bufferValid), 16'((1 << (n + 1)) - 1));
        end
        // A forced update transfers and clears even while locked.
        lockUpdate = 1'b1;
        periodBuffer = 16'($urandom);
        updateCommand = 1'b1;
        @(negedge clk);
        updateCommand = 1'b0;
        check({bufferValid, periodValue}, {4'h0, periodBuffer});
        r = 8'($urandom);
        wr(OFS_BV_SET, r);
        wr(OFS_BV_SET, 8'h00);
        rd(OFS_BV_SET, b);
        check({bufferValid, b}, {r[3:0], 4'h0, r[3:0]});
        // Wrap at top when counting up, at bottom in single-slope mode.
        wr(OFS_INT_EN, 8'h71);
        wr16(OFS_PERIOD, 16'h0003);
        // Single-slope counts down from zero under the direction action; frequency
        // mode takes its top from compare channel 0, which also matches first.
        for (int m = 0; m < 3; m++) begin
            waveformMode = (m == 2) ? MODE_FREQUENCY : (m == 1) ? MODE_SINGLE : MODE_NORMAL;
            lockUpdate = (m == 0);
            periodBuffer = 16'($urandom);
            compareValues[0] = (m == 2) ? 16'h0005 : 16'h8000;
            wr(OFS_EVENT, (m == 1) ? 8'h07 : 8'h00);
            wr16(OFS_COUNTER, (m == 1) ? 16'h0000 : (m == 2) ? 16'h0005 : 16'h0003);
            wr(OFS_BV_SET, 8'h0f);
            wr(OFS_INT_FLAGS, 8'h71);
            {timerEnable, prescaleTick, eventIn} = {2'b11, m == 1};
            @(negedge clk);
            {timerEnable, prescaleTick, eventIn} = 3'b000;
            @(negedge clk);
            check(counterValue, (m == 1) ? 16'h0003 : 16'h0000);
            check(16'({wrapIrq, bufferValid}), (m == 0) ? 16'h001f : 16'h0010);
            check(periodValue, (m == 0) ? 16'h0003 : periodBuffer);
            rd(OFS_INT_FLAGS, b);
            check(16'(b), (m == 2) ? 16'h0011 : 16'h0001);
        end
        // Compare match per channel: sticky flag, request, one-to-clear.
        for (int n = 0; n < 3; n++) begin
            model = 16'($urandom);
            wr16(OFS_COUNTER, model);
            compareValues = '{default: model ^ 16'h0001};
            compareValues[n] = model;
            wr(OFS_INT_FLAGS, 8'h71);
            rd(OFS_INT_FLAGS, b);
            check({5'h00, compareIrq, b}, {5'h00, 3'(1 << n), 8'(8'h10 << n)});
            compareValues[n] = model ^ 16'h0003;
            wr(OFS_INT_FLAGS, 8'h00);
            rd(OFS_INT_FLAGS, b);
            check(16'(b), 16'(8'h10 << n));
            wr(OFS_INT_FLAGS, 8'(8'h10 << n));
            rd(OFS_INT_FLAGS, b);
            check({5'h00, compareIrq, b}, 16'h0000);
        end
        end_of_test();
    end
endmodule : tb_timer_buffer_event_irq_regs
`default_nettype wire
